// >>> hw/gits_irq_ctrl.sv
// grouped interrupt, comparator and tick interrupt controller
// assumes all inputs synchronous to ref_clk_i, core pulses ack one cycle
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "gits_regs.svh"

module gits_irq_ctrl
(
	input  logic                 ref_clk_i,
	input  logic                 rst_n_i,
	input  logic [7:0]           addr_i,
	input  logic [7:0]           wdata_i,
	input  logic                 wr_i,
	input  logic                 rd_i,
	output logic [7:0]           rdata_o,
	input  gits_pkg::gits_evt_t  evt_i,
	input  logic [1:0]           comp_out_i,
	input  logic                 slow_low_clock_i,
	input  gits_pkg::gits_core_t core_i,
	output logic                 irq_req_o,
	output gits_pkg::gits_vec_t  irq_vec_o,
	output logic                 global_irq_enable_o,
	output logic                 wake_o
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [14:0] tick_mask(input logic [2:0] per);
		tick_mask = `GITS_CNT_ALL >> (`GITS_PER_MAX - per);
	endfunction

	function automatic gits_pkg::gits_vec_t pick_vec(input logic [5:0] pend);
		if (pend[2])
			pick_vec = gits_pkg::GITS_VEC_CMP0;
		else if (pend[3])
			pick_vec = gits_pkg::GITS_VEC_CMP1;
		else if (pend[0])
			pick_vec = gits_pkg::GITS_VEC_GRP0;
		else if (pend[1])
			pick_vec = gits_pkg::GITS_VEC_GRP1;
		else if (pend[4])
			pick_vec = gits_pkg::GITS_VEC_TICK0;
		else
			pick_vec = gits_pkg::GITS_VEC_TICK1;
	endfunction

	function automatic logic [5:0] vec_bit(input gits_pkg::gits_vec_t v);
		vec_bit = 6'h00;
		case (v)
			gits_pkg::GITS_VEC_CMP0:  vec_bit = 6'h04;
			gits_pkg::GITS_VEC_CMP1:  vec_bit = 6'h08;
			gits_pkg::GITS_VEC_GRP0:  vec_bit = 6'h01;
			gits_pkg::GITS_VEC_GRP1:  vec_bit = 6'h02;
			gits_pkg::GITS_VEC_TICK0: vec_bit = 6'h10;
			default:                  vec_bit = 6'h20;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	// flag and enable bits: 0 grp0, 1 grp1, 2 cmp0, 3 cmp1, 4 tick0, 5 tick1
	logic [5:0]                 flag_q, flag_d;
	logic [5:0]                 ien_q, ien_d;
	logic                       gie_q, gie_d;
	logic [7:0]                 grp0_q, grp0_d;
	logic [7:0]                 grp1_q, grp1_d;
	logic [1:0]                 cmp_prev_q, cmp_prev_d;
	logic [1:0]                 tb_run_q, tb_run_d;
	logic [1:0][2:0]            tb_per_q, tb_per_d;
	logic [1:0][1:0]            tb_src_q, tb_src_d;
	logic [1:0][14:0]           tb_cnt_q, tb_cnt_d;
	logic [1:0]                 div4_q, div4_d;
	logic [7:0]                 rdata_q, rdata_d;
	logic                       req_q, req_d;
	gits_pkg::gits_vec_t        vec_q, vec_d;
	logic                       wake_q, wake_d;

	logic [3:0]                 g0_set, g1_set;
	logic [1:0]                 grp_set;
	logic [1:0]                 cmp_chg;
	logic [1:0]                 tb_tick;
	logic [1:0]                 tb_ovf;
	logic                       taken;
	logic [5:0]                 pend;
	logic                       wr_ctrl, wr_ien, wr_flag, wr_g0, wr_g1;
	logic                       wr_tb0, wr_tb1, wr_ps0, wr_ps1;

	assign rdata_o             = rdata_q;
	assign irq_req_o           = req_q;
	assign irq_vec_o           = vec_q;
	assign global_irq_enable_o = gie_q;
	assign wake_o              = wake_q;

	////////////////////////////////////////////////////////////////////////////
	// write decode

	always_comb
	begin
		wr_ctrl = 1'b0;
		wr_ien  = 1'b0;
		wr_flag = 1'b0;
		wr_g0   = 1'b0;
		wr_g1   = 1'b0;
		wr_tb0  = 1'b0;
		wr_tb1  = 1'b0;
		wr_ps0  = 1'b0;
		wr_ps1  = 1'b0;
		if (!wr_i)
			wr_ctrl = 1'b0;
		else if (addr_i == `GITS_A_CTRL)
			wr_ctrl = 1'b1;
		else if (addr_i == `GITS_A_IEN)
			wr_ien = 1'b1;
		else if (addr_i == `GITS_A_FLAG)
			wr_flag = 1'b1;
		else if (addr_i == `GITS_A_GRP0)
			wr_g0 = 1'b1;
		else if (addr_i == `GITS_A_GRP1)
			wr_g1 = 1'b1;
		else if (addr_i == `GITS_A_TICK0_CTL)
			wr_tb0 = 1'b1;
		else if (addr_i == `GITS_A_TICK1_CTL)
			wr_tb1 = 1'b1;
		else if (addr_i == `GITS_A_PSC0)
			wr_ps0 = 1'b1;
		else if (addr_i == `GITS_A_PSC1)
			wr_ps1 = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// tick dividers

	always_comb
	begin
		div4_d   = div4_q + 2'h1;
		tb_run_d = tb_run_q;
		tb_per_d = tb_per_q;
		tb_src_d = tb_src_q;
		if (wr_tb0)
		begin
			tb_run_d[0] = wdata_i[`GITS_TB_RUN];
			tb_per_d[0] = wdata_i[2:0];
		end
		if (wr_tb1)
		begin
			tb_run_d[1] = wdata_i[`GITS_TB_RUN];
			tb_per_d[1] = wdata_i[2:0];
		end
		if (wr_ps0)
			tb_src_d[0] = wdata_i[1:0];
		if (wr_ps1)
			tb_src_d[1] = wdata_i[1:0];
		for (int i = 0; i < 2; i++)
		begin
			// source mux: sys, sys/4, slow clock tick
			if (tb_src_q[i] == `GITS_PSC_SYS)
				tb_tick[i] = 1'b1;
			else if (tb_src_q[i] == `GITS_PSC_DIV4)
				tb_tick[i] = (div4_q == `GITS_DIV4_LAST);
			else
				tb_tick[i] = slow_low_clock_i;
			tb_ovf[i] = tb_run_q[i] && tb_tick[i] &&
			            ((tb_cnt_q[i] & tick_mask(tb_per_q[i])) == tick_mask(tb_per_q[i]));
			if (!tb_run_q[i])
				tb_cnt_d[i] = '0;
			else if (tb_tick[i])
				tb_cnt_d[i] = tb_cnt_q[i] + 15'h0001;
			else
				tb_cnt_d[i] = tb_cnt_q[i];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div4_q   <= 2'h0;
			tb_run_q <= 2'h0;
			tb_per_q <= '0;
			tb_src_q <= '0;
			tb_cnt_q <= '0;
		end
		else
		begin
			div4_q   <= div4_d;
			tb_run_q <= tb_run_d;
			tb_per_q <= tb_per_d;
			tb_src_q <= tb_src_d;
			tb_cnt_q <= tb_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flags, enables and vectoring

	always_comb
	begin
		// member bytes: flags [7:4], enables [3:0]
		g0_set = {evt_i.timer_match_a[0], evt_i.timer_match_p[0],
		          evt_i.timer_match_a[1], evt_i.timer_match_p[1]};
		g1_set = {evt_i.eeprom_done, evt_i.low_voltage,
		          evt_i.timer_match_a[2], evt_i.timer_match_p[2]};
		cmp_chg    = comp_out_i ^ cmp_prev_q;
		cmp_prev_d = comp_out_i;
		taken      = core_i.irq_ack && req_q;

		grp0_d = wr_g0 ? wdata_i : grp0_q;
		grp1_d = wr_g1 ? wdata_i : grp1_q;
		grp0_d[7:4] = grp0_d[7:4] | g0_set;
		grp1_d[7:4] = grp1_d[7:4] | g1_set;
		// a member rising while its enable is set raises the group flag
		grp_set[0] = |(grp0_d[7:4] & ~grp0_q[7:4] & grp0_q[3:0]);
		grp_set[1] = |(grp1_d[7:4] & ~grp1_q[7:4] & grp1_q[3:0]);

		ien_d  = wr_ien ? wdata_i[5:0] : ien_q;
		flag_d = wr_flag ? wdata_i[5:0] : flag_q;
		if (taken)
			flag_d = flag_d & ~vec_bit(vec_q);
		flag_d = flag_d | {tb_ovf, cmp_chg, grp_set};

		gie_d = wr_ctrl ? wdata_i[`GITS_CTRL_GIE] : gie_q;
		if (core_i.return_from_irq)
			gie_d = 1'b1;
		if (taken)
			gie_d = 1'b0;

		pend  = flag_q & ien_q;
		req_d = gie_q && !core_i.stack_full && (|pend) && !taken;
		vec_d = pick_vec(pend);

		wake_d = (|(flag_d & ~flag_q)) ||
		         (|(grp0_d[7:4] & ~grp0_q[7:4])) || (|(grp1_d[7:4] & ~grp1_q[7:4]));

		rdata_d = `GITS_RST_BYTE;
		if (!rd_i)
			rdata_d = `GITS_RST_BYTE;
		else if (addr_i == `GITS_A_CTRL)
			rdata_d = {7'h00, gie_q};
		else if (addr_i == `GITS_A_IEN)
			rdata_d = {2'h0, ien_q};
		else if (addr_i == `GITS_A_FLAG)
			rdata_d = {2'h0, flag_q};
		else if (addr_i == `GITS_A_GRP0)
			rdata_d = grp0_q;
		else if (addr_i == `GITS_A_GRP1)
			rdata_d = grp1_q;
		else if (addr_i == `GITS_A_TICK0_CTL)
			rdata_d = {tb_run_q[0], 4'h0, tb_per_q[0]};
		else if (addr_i == `GITS_A_TICK1_CTL)
			rdata_d = {tb_run_q[1], 4'h0, tb_per_q[1]};
		else if (addr_i == `GITS_A_PSC0)
			rdata_d = {6'h00, tb_src_q[0]};
		else if (addr_i == `GITS_A_PSC1)
			rdata_d = {6'h00, tb_src_q[1]};
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			flag_q     <= 6'h00;
			ien_q      <= 6'h00;
			gie_q      <= 1'b0;
			grp0_q     <= 8'h00;
			grp1_q     <= 8'h00;
			cmp_prev_q <= 2'h0;
			req_q      <= 1'b0;
			vec_q      <= gits_pkg::GITS_VEC_CMP0;
			wake_q     <= 1'b0;
			rdata_q    <= 8'h00;
		end
		else
		begin
			flag_q     <= flag_d;
			ien_q      <= ien_d;
			gie_q      <= gie_d;
			grp0_q     <= grp0_d;
			grp1_q     <= grp1_d;
			cmp_prev_q <= cmp_prev_d;
			req_q      <= req_d;
			vec_q      <= vec_d;
			wake_q     <= wake_d;
			rdata_q    <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	property p_grp_serv_clear;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		taken && vec_q == gits_pkg::GITS_VEC_GRP0 && !grp_set[0]
		|=> !flag_q[0] && !gie_q;
	endproperty
	a_grp_serv_clear: assert property (p_grp_serv_clear)
		else $error("group flag or global enable not cleared on service");

	property p_member_kept;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		taken && !wr_g0 |=> (grp0_q[7:4] & $past(grp0_q[7:4])) == $past(grp0_q[7:4]);
	endproperty
	a_member_kept: assert property (p_member_kept)
		else $error("member flag cleared by group service");

	property p_no_req_without_gie;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!gie_q || core_i.stack_full |=> !irq_req_o;
	endproperty
	a_no_req_without_gie: assert property (p_no_req_without_gie)
		else $error("request raised without global enable or stack room");

	property p_cmp_change;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		comp_out_i[0] != cmp_prev_q[0] |=> flag_q[2] && cmp_prev_q[0] == $past(comp_out_i[0]);
	endproperty
	a_cmp_change: assert property (p_cmp_change)
		else $error("comparator change did not set flag");

	property p_cmp_serv;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		taken && vec_q == gits_pkg::GITS_VEC_CMP0 && !cmp_chg[0] |=> !flag_q[2] && !gie_q;
	endproperty
	a_cmp_serv: assert property (p_cmp_serv)
		else $error("comparator service did not clear flag");

	property p_tick_set;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		tb_ovf[0] |=> flag_q[4];
	endproperty
	a_tick_set: assert property (p_tick_set)
		else $error("tick overflow lost");

	property p_tick_stop;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!tb_run_q[1] && !wr_tb1 |=> tb_cnt_q[1] == 15'h0000 && !tb_ovf[1];
	endproperty
	a_tick_stop: assert property (p_tick_stop)
		else $error("tick divider ran while disabled");

	property p_return_from_irq;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		core_i.return_from_irq && !taken |=> gie_q;
	endproperty
	a_return_from_irq: assert property (p_return_from_irq)
		else $error("return did not restore global enable");

	property p_wake;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(flag_q[5]) |-> wake_o;
	endproperty
	a_wake: assert property (p_wake)
		else $error("flag rise without wake request");

	property p_psc_read;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == `GITS_A_PSC0 |=> rdata_o[7:2] == 6'h00 && rdata_o[1:0] == tb_src_q[0];
	endproperty
	a_psc_read: assert property (p_psc_read)
		else $error("prescaler select read wrong");

	property p_prio;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(flag_q[2] && ien_q[2] && flag_q[4] && ien_q[4]) |=> irq_vec_o == gits_pkg::GITS_VEC_CMP0;
	endproperty
	a_prio: assert property (p_prio)
		else $error("priority order violated");

endmodule

// >>> hw/gits_regs.svh
// register offsets, field positions and reset values of the grouped irq block
// assumes byte-wide registers on a plain strobe port
`ifndef GITS_REGS_SVH
`define GITS_REGS_SVH

`define GITS_A_CTRL      8'h00
`define GITS_A_IEN       8'h01
`define GITS_A_FLAG      8'h02
`define GITS_A_GRP0      8'h03
`define GITS_A_GRP1      8'h04
`define GITS_A_TICK0_CTL 8'h05
`define GITS_A_TICK1_CTL 8'h06
`define GITS_A_PSC0      8'h07
`define GITS_A_PSC1      8'h08

`define GITS_CTRL_GIE    0
`define GITS_TB_RUN      7
`define GITS_NSRC        6
`define GITS_CNT_W       15
`define GITS_CNT_ALL     15'h7fff
`define GITS_PER_MAX     3'h7
`define GITS_PSC_SYS     2'h0
`define GITS_PSC_DIV4    2'h1
`define GITS_DIV4_LAST   2'h3
`define GITS_RST_BYTE    8'h00

`endif

// >>> hw/gits_pkg.sv
// types of the grouped irq and tick source block
// assumes gits_regs.svh for register constants, vector codes are set here
package gits_pkg;

	// vector codes, in fixed priority order, lowest code wins
	typedef enum logic [2:0] {
		GITS_VEC_CMP0  = 3'b000,
		GITS_VEC_CMP1  = 3'b001,
		GITS_VEC_GRP0  = 3'b010,
		GITS_VEC_GRP1  = 3'b011,
		GITS_VEC_TICK0 = 3'b100,
		GITS_VEC_TICK1 = 3'b101
	} gits_vec_t;

	// peripheral event pulses, index is timer module number
	typedef struct packed {
		logic [2:0] timer_match_a;
		logic [2:0] timer_match_p;
		logic       low_voltage;
		logic       eeprom_done;
	} gits_evt_t;

	// core side handshake
	typedef struct packed {
		logic irq_ack;
		logic return_from_irq;
		logic stack_full;
	} gits_core_t;

endpackage

// >>> verification/gits_core_model.sv
// core side model: takes vectors, returns from service a few cycles later
// assumes the controller's clock and reset
`timescale 1ns/1ps

module gits_core_model
(
	input  logic                 ref_clk_i,
	input  logic                 rst_n_i,
	input  logic                 irq_req_i,
	input  gits_pkg::gits_vec_t  irq_vec_i,
	input  logic                 stack_full_i,
	input  logic                 slow_i,
	output gits_pkg::gits_core_t core_o,
	output logic [2:0]           vec_o,
	output logic                 took_o
);
	logic [1:0] wait_q;
	logic [2:0] ret_q;

	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			core_o <= '0;
			vec_o  <= '0;
			took_o <= 1'b0;
			wait_q <= '0;
			ret_q  <= '0;
		end
		else
		begin
			core_o.irq_ack    <= 1'b0;
			core_o.stack_full <= stack_full_i;
			took_o            <= 1'b0;
			core_o.return_from_irq <= (ret_q == 3'h1);
			if (ret_q != 3'h0)
				ret_q <= ret_q - 3'h1;
			else if (irq_req_i)
			begin
				// slow core holds off the ack a few cycles
				if (slow_i && wait_q != 2'h3)
					wait_q <= wait_q + 2'h1;
				else
				begin
					core_o.irq_ack <= 1'b1;
					vec_o          <= irq_vec_i;
					took_o         <= 1'b1;
					wait_q         <= '0;
					ret_q          <= 3'h4;
				end
			end
		end
	end
endmodule

// >>> verification/gits_irq_ctrl_tb.sv
// self-checking bench of the grouped irq and tick controller
// assumes gits_core_model on the core side, one 50 MHz clock
`timescale 1ns/1ps

module gits_irq_ctrl_tb;
	logic                 ref_clk_i;
	logic                 rst_n_i;
	logic [7:0]           addr_i;
	logic [7:0]           wdata_i;
	logic                 wr_i;
	logic                 rd_i;
	logic [7:0]           rdata_o;
	gits_pkg::gits_evt_t  evt_i;
	logic [1:0]           comp_out_i;
	logic                 slow_low_clock_i;
	gits_pkg::gits_core_t core_i;
	logic                 irq_req_o;
	gits_pkg::gits_vec_t  irq_vec_o;
	logic                 global_irq_enable_o;
	logic                 wake_o;
	logic                 stack_full;
	logic                 slow;
	logic [2:0]           took_vec;
	logic                 took;
	logic [7:0]           d;
	logic [7:0]           m;
	int                   err_count = 0;
	int                   checks_done = 0;
	int                   cyc = 0;
	int                   wake_cnt = 0;
	int                   wake_cyc = 0;
	int                   seed;
	int                   n;
	int                   t0;
	int                   tk_t[5] = '{0, 1, 0, 1, 0};
	int                   tk_s[5] = '{0, 1, 2, 3, 0};
	int                   tk_c[5] = '{0, 0, 1, 0, 2};
	int                   tk_m[5] = '{1, 4, 2, 2, 1};

	gits_irq_ctrl u_gits_irq_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt_i),
		.comp_out_i(comp_out_i), .slow_low_clock_i(slow_low_clock_i), .core_i(core_i),
		.irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o),
		.global_irq_enable_o(global_irq_enable_o), .wake_o(wake_o));

	gits_core_model u_gits_core_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.irq_req_i(irq_req_o), .irq_vec_i(irq_vec_o), .stack_full_i(stack_full),
		.slow_i(slow), .core_o(core_i), .vec_o(took_vec), .took_o(took));

	initial
	begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	// slow tick every other cycle, wake pulse log
	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		slow_low_clock_i <= ~slow_low_clock_i;
		if (wake_o === 1'b1)
		begin
			wake_cnt <= wake_cnt + 1;
			wake_cyc <= cyc;
		end
	end

	////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask

	task automatic chk_t(input string s, input int e, input int g);
		checks_done++;
		if (g < e - 8 || g > e + 8)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %0d got %0d", s, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask

	task automatic pulse(input logic [7:0] e);
		@(posedge ref_clk_i);
		evt_i <= e;
		@(posedge ref_clk_i);
		evt_i <= '0;
	endtask

	// waits for the core to take a vector, then checks service side effects
	task automatic take(input logic [2:0] v);
		for (int k = 0; k < 60 && took !== 1'b1; k++)
		begin
			@(posedge ref_clk_i);
			#1;
		end
		chk("vector", {5'h0, v}, {5'h0, took_vec});
		@(posedge ref_clk_i);
		#1;
		chk("gie off", 8'h00, {7'h0, global_irq_enable_o});
	endtask

	function automatic logic [7:0] mem_bits(input logic [7:0] e);
		return {e[5], e[2], e[6], e[3], e[0], e[1], e[7], e[4]};
	endfunction

	////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'h5c06fd74;
		rst_n_i = 1'b0;
		{addr_i, wdata_i, wr_i, rd_i, evt_i, comp_out_i} = '0;
		{slow_low_clock_i, stack_full, slow} = '0;
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (int a = 0; a < 10; a++)
		begin
			rd(8'(a), d);
			chk("reset", 8'h00, d);
		end
		for (int a = 5; a < 9; a++)
		begin
			wr(8'(a), 8'hff);
			rd(8'(a), d);
			chk("mask", (a < 7) ? 8'h87 : 8'h03, d);
			wr(8'(a), 8'h00);
		end
		m = 8'h00;
		n = wake_cnt;
		repeat (12)
		begin
			d = 8'($random(seed));
			pulse(d);
			m = m | mem_bits(d);
		end
		rd(8'h03, d);
		chk("grp0", {m[7:4], 4'h0}, d);
		rd(8'h04, d);
		chk("grp1", {m[3:0], 4'h0}, d);
		rd(8'h02, d);
		chk("flags", 8'h00, d);
		chk("wake", {7'h0, m != 8'h00}, {7'h0, wake_cnt > n});
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h00);
		wr(8'h03, 8'h08);
		wr(8'h01, 8'h01);
		wr(8'h00, 8'h01);
		stack_full <= 1'b1;
		pulse(8'h20);
		repeat (10) @(posedge ref_clk_i);
		#1;
		chk("stack full", 8'h00, {7'h0, irq_req_o});
		@(posedge ref_clk_i);
		stack_full <= 1'b0;
		take(3'h2);
		rd(8'h02, d);
		chk("grp flag", 8'h00, d);
		rd(8'h03, d);
		chk("member", 8'h88, d);
		repeat (8) @(posedge ref_clk_i);
		#1;
		chk("gie back", 8'h01, {7'h0, global_irq_enable_o});
		wr(8'h03, 8'h00);
		wr(8'h01, 8'h08);
		comp_out_i <= 2'b10;
		take(3'h1);
		@(posedge ref_clk_i);
		comp_out_i <= 2'b00;
		take(3'h1);
		rd(8'h02, d);
		chk("cmp flag", 8'h00, d);
		@(posedge ref_clk_i);
		comp_out_i <= 2'b01;
		rd(8'h02, d);
		chk("cmp0 flag", 8'h04, d);
		wr(8'h02, 8'h00);
		repeat (8) @(posedge ref_clk_i);
		wr(8'h01, 8'h3f);
		wr(8'h02, 8'h3f);
		for (int v = 0; v < 6; v++)
		begin
			slow <= (v > 2);
			take(3'(v));
		end
		rd(8'h02, d);
		chk("all served", 8'h00, d);
		wr(8'h01, 8'h00);
		foreach (tk_s[i])
		begin
			wr(8'(7 + tk_t[i]), 8'(tk_s[i]));
			n = wake_cnt;
			wr(8'(5 + tk_t[i]), 8'(8'h80 | tk_c[i]));
			t0 = cyc;
			for (int k = 0; k < 5000 && wake_cnt == n; k++)
				@(posedge ref_clk_i);
			chk_t("period", (256 << tk_c[i]) * tk_m[i], wake_cyc - t0);
			rd(8'h02, d);
			chk("tick flag", 8'(8'h10 << tk_t[i]), d);
			wr(8'h02, 8'h00);
			wr(8'(5 + tk_t[i]), 8'h00);
			n = wake_cnt;
			repeat (1100) @(posedge ref_clk_i);
			chk("stopped", 8'h00, 8'(wake_cnt - n));
		end
		stop_test();
	end

	initial
	begin
		#1000000;
		err_count++;
		stop_test();
	end
endmodule
